// [pkg/csbe_pkg.sv]
// Shared types and constants for the logic/shift/branch execute slice.
// Assumes a single core clock and a synchronous, active-high reset.
`default_nettype none

package csbe_pkg;

  // Widths of the datapath, program counter and data file
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PC_W = 15;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned FILE_DEPTH = 128;
  localparam int unsigned BIT_IDX_W = 3;
  localparam int unsigned LIT_W = 9;

  // Bit positions used by the shift
  localparam int unsigned MSB_POS = 7;
  localparam int unsigned LSB_POS = 0;

  // Destination select encoding
  localparam logic DEST_W_REG = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  // Values after reset
  localparam logic [PC_W-1:0] RESET_PC = 15'h0000;
  localparam logic [DATA_W-1:0] RESET_W = 8'h00;
  localparam logic RESET_C = 1'b0;
  localparam logic RESET_Z = 1'b0;

  // Fixed increments and cycle counts
  localparam logic [PC_W-1:0] PC_STEP = 15'h0001;
  localparam int unsigned BRANCH_CYCLES = 2;
  localparam int unsigned SKIP_CYCLES = 2;

  // Decoded operations handled by this slice
  typedef enum logic [3:0] {
    CSBE_OP_NOP,
    CSBE_OP_AND_LITERAL_W,
    CSBE_OP_AND_W_FILE,
    CSBE_OP_ARITH_SHIFT_RIGHT_FILE,
    CSBE_OP_BIT_CLEAR_FILE,
    CSBE_OP_BIT_SET_FILE,
    CSBE_OP_RELATIVE_JUMP_LITERAL,
    CSBE_OP_RELATIVE_JUMP_WREG,
    CSBE_OP_BIT_TEST_SKIP_CLEAR
  } csbe_op_t;

  // One decoded instruction as delivered by program memory
  typedef struct packed {
    csbe_op_t op;
    logic [FADDR_W-1:0] faddr;
    logic dest;
    logic [BIT_IDX_W-1:0] bit_idx;
    logic [LIT_W-1:0] lit;
  } csbe_instr_t;

  localparam csbe_instr_t INSTR_NOP = '{op: CSBE_OP_NOP, faddr: 7'h00, dest: 1'b0, bit_idx: 3'h0, lit: 9'h000};

  // Write request toward the data file
  typedef struct packed {
    logic en;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } csbe_file_wr_t;

  // Architectural and pipeline state of the core, except the data file contents
  typedef struct packed {
    logic [PC_W-1:0] pc;
    csbe_instr_t ir;
    logic [DATA_W-1:0] w;
    logic c;
    logic z;
    logic retired;
    logic flushed;
    logic illegal;
  } csbe_state_t;

  localparam csbe_state_t RESET_STATE = '{
    pc: RESET_PC,
    ir: INSTR_NOP,
    w: RESET_W,
    c: RESET_C,
    z: RESET_Z,
    retired: 1'b0,
    flushed: 1'b0,
    illegal: 1'b0
  };

endpackage

`default_nettype wire

// [hw/csbe_file_bank.sv]
// Data register file: 128 bytes, one combinational read port for the
// execute stage, one write port and a registered debug read port.
// Assumes writes come from one source; contents are not cleared by reset.
`default_nettype none

module csbe_file_bank
  import csbe_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Execute read port
  input wire logic [FADDR_W-1:0] rd_addr_i,
  output logic [DATA_W-1:0] rd_data_o,
  // Execute write port
  input wire csbe_file_wr_t wr_i,
  // Debug read port
  input wire logic [FADDR_W-1:0] dbg_addr_i,
  output logic [DATA_W-1:0] dbg_data_o
);

  logic [DATA_W-1:0] mem [FILE_DEPTH];
  logic [DATA_W-1:0] dbg_q;

  // Asynchronous read keeps the execute stage single cycle
  assign rd_data_o = mem[rd_addr_i];
  assign dbg_data_o = dbg_q;

  // Array write; no reset so it maps onto plain storage
  always_ff @(posedge core_clk_i) begin
    if (wr_i.en) begin
      mem[wr_i.addr] <= wr_i.data;
    end
  end

  // Debug read shows the value before any write in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      dbg_q <= '0;
    end else begin
      dbg_q <= mem[dbg_addr_i];
    end
  end

endmodule

`default_nettype wire

// [hw/csbe_core.sv]
// Execute core for the logic, shift, bit and relative-branch slice of a
// small 8-bit controller: two-stage fetch/execute with a flushable IR.
// Assumes program memory answers prog_addr_o combinationally on instr_i.
//
// How it works
// - and_literal_w: W AND 8-bit literal into W, only Z changes.
// - and_w_file: W AND addressed file byte, only Z changes.
// - Destination bit 0 writes W, 1 writes the addressed file byte.
// - arith_shift_right_file: shift right, keep bit 7, bit 0 to C.
// - bit_clear_file: clear chosen bit of file byte, flags untouched.
// - bit_set_file: set chosen bit of file byte, flags untouched.
// - relative_jump_literal: PC becomes next address plus signed 9-bit offset.
// - relative_jump_wreg: PC becomes next address plus unsigned W, two cycles.
// - bit_test_skip_clear with bit zero: fetched instruction becomes a NOP.
// - bit_test_skip_clear with bit one: continue normally, flags untouched.
`default_nettype none

module csbe_core
  import csbe_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Program memory
  output logic [PC_W-1:0] prog_addr_o,
  input wire csbe_instr_t instr_i,
  // Architectural state view
  output logic [DATA_W-1:0] w_o,
  output logic carry_o,
  output logic zero_o,
  // Execution status
  output logic retired_o,
  output logic flushed_o,
  output logic illegal_o,
  // Data file debug access
  input wire logic [FADDR_W-1:0] dbg_addr_i,
  output logic [DATA_W-1:0] dbg_data_o
);

  csbe_state_t s_q;
  csbe_state_t s_d;
  csbe_file_wr_t file_wr;
  logic [DATA_W-1:0] file_rd;
  logic [DATA_W-1:0] result;
  logic [DATA_W-1:0] bit_mask;
  logic [PC_W-1:0] pc_next;
  logic [PC_W-1:0] lit_offset;
  logic [PC_W-1:0] w_offset;
  logic tested_bit;

  // Data file sits beside the core; read address follows the IR
  csbe_file_bank u_file_bank (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .rd_addr_i(s_q.ir.faddr),
    .rd_data_o(file_rd),
    .wr_i(file_wr),
    .dbg_addr_i(dbg_addr_i),
    .dbg_data_o(dbg_data_o)
  );

  // Operand helpers shared by several operations
  assign bit_mask = 8'h01 << s_q.ir.bit_idx;
  assign tested_bit = file_rd[s_q.ir.bit_idx];
  assign pc_next = s_q.pc + PC_STEP;
  // The PC already points past the executing instruction, so it is the base
  assign lit_offset = {{(PC_W - LIT_W){s_q.ir.lit[LIT_W-1]}}, s_q.ir.lit};
  assign w_offset = {{(PC_W - DATA_W){1'b0}}, s_q.w};

  // Next-state logic: execute IR while the next word is being fetched
  always_comb begin
    s_d = s_q;
    result = '0;
    file_wr = '0;
    s_d.ir = instr_i;
    s_d.pc = pc_next;
    s_d.retired = 1'b1;
    s_d.flushed = 1'b0;
    s_d.illegal = 1'b0;
    unique case (s_q.ir.op)
      CSBE_OP_NOP: begin
        // Forced NOPs from a flush report as such, not as retirements
        s_d.retired = ~s_q.flushed;
      end
      CSBE_OP_AND_LITERAL_W: begin
        result = s_q.w & s_q.ir.lit[DATA_W-1:0];
        s_d.w = result;
        s_d.z = (result == 8'h00);
      end
      CSBE_OP_AND_W_FILE: begin
        result = s_q.w & file_rd;
        s_d.z = (result == 8'h00);
        if (s_q.ir.dest == DEST_FILE) begin
          file_wr = '{en: 1'b1, addr: s_q.ir.faddr, data: result};
        end else begin
          s_d.w = result;
        end
      end
      CSBE_OP_ARITH_SHIFT_RIGHT_FILE: begin
        result = {file_rd[MSB_POS], file_rd[MSB_POS:1]};
        s_d.c = file_rd[LSB_POS];
        s_d.z = (result == 8'h00);
        if (s_q.ir.dest == DEST_FILE) begin
          file_wr = '{en: 1'b1, addr: s_q.ir.faddr, data: result};
        end else begin
          s_d.w = result;
        end
      end
      CSBE_OP_BIT_CLEAR_FILE: begin
        // Read-modify-write of the whole byte; C and Z are left alone
        result = file_rd & ~bit_mask;
        file_wr = '{en: 1'b1, addr: s_q.ir.faddr, data: result};
      end
      CSBE_OP_BIT_SET_FILE: begin
        result = file_rd | bit_mask;
        file_wr = '{en: 1'b1, addr: s_q.ir.faddr, data: result};
      end
      CSBE_OP_RELATIVE_JUMP_LITERAL: begin
        // The word fetched this cycle is dropped, giving the second cycle
        s_d.pc = s_q.pc + lit_offset;
        s_d.ir = INSTR_NOP;
        s_d.flushed = 1'b1;
      end
      CSBE_OP_RELATIVE_JUMP_WREG: begin
        s_d.pc = s_q.pc + w_offset;
        s_d.ir = INSTR_NOP;
        s_d.flushed = 1'b1;
      end
      CSBE_OP_BIT_TEST_SKIP_CLEAR: begin
        if (!tested_bit) begin
          s_d.ir = INSTR_NOP;
          s_d.flushed = 1'b1;
        end else begin
          // A set bit falls through: IR and PC advance as usual
          s_d.ir = instr_i;
        end
      end
      default: begin
        // Codes outside the slice execute as NOP and are flagged
        s_d.illegal = 1'b1;
        s_d.retired = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  // All outputs except dbg_data_o are taken straight from the state register
  assign prog_addr_o = s_q.pc;
  assign w_o = s_q.w;
  assign carry_o = s_q.c;
  assign zero_o = s_q.z;
  assign retired_o = s_q.retired;
  assign flushed_o = s_q.flushed;
  assign illegal_o = s_q.illegal;

endmodule

`default_nettype wire

// [dv/csbe_core_assertions.sv]
// Concurrent checks for the execute slice, seen from csbe_core ports.
// Assumes the bind sits in the testbench top file.
`default_nettype none

module csbe_core_assertions
  import csbe_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Core ports
  input wire logic [PC_W-1:0] prog_addr_o,
  input wire csbe_instr_t instr_i,
  input wire logic [DATA_W-1:0] w_o,
  input wire logic carry_o,
  input wire logic zero_o,
  input wire logic retired_o,
  input wire logic flushed_o,
  input wire logic illegal_o
);
  csbe_instr_t ir_q;
  logic live_q;
  logic ex;

  // Shadow of the hidden IR, so checks know what executes
  always_ff @(posedge core_clk_i) begin
    ir_q <= instr_i;
    live_q <= !srst_i;
  end
  // Forced NOP after a flush executes nothing
  assign ex = live_q && !flushed_o && !srst_i;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  AST_AND_LIT: assert property (ex && ir_q.op == CSBE_OP_AND_LITERAL_W |=>
    w_o == ($past(w_o) & $past(ir_q.lit[7:0])) && $stable(carry_o) && zero_o == (w_o == 8'h00))
    else $error("and literal result or flags wrong");
  AST_AND_FILE: assert property (ex && ir_q.op == CSBE_OP_AND_W_FILE && ir_q.dest == DEST_W_REG |=>
    (w_o & ~$past(w_o)) == 8'h00 && $stable(carry_o) && zero_o == (w_o == 8'h00))
    else $error("and file result or flags wrong");
  AST_DEST_FILE: assert property (ex && ir_q.dest == DEST_FILE && (ir_q.op == CSBE_OP_AND_W_FILE ||
    ir_q.op == CSBE_OP_ARITH_SHIFT_RIGHT_FILE) |=> $stable(w_o))
    else $error("file destination disturbed W");
  AST_ASR: assert property (ex && ir_q.op == CSBE_OP_ARITH_SHIFT_RIGHT_FILE && ir_q.dest == DEST_W_REG |=>
    w_o[7] == w_o[6] && zero_o == (w_o == 8'h00))
    else $error("shift lost sign or zero flag wrong");
  AST_BIT_OPS: assert property (ex && (ir_q.op == CSBE_OP_BIT_CLEAR_FILE || ir_q.op == CSBE_OP_BIT_SET_FILE) |=>
    $stable({w_o, carry_o, zero_o}) && !flushed_o)
    else $error("bit operation changed W or flags");
  AST_JUMP_LIT: assert property (ex && ir_q.op == CSBE_OP_RELATIVE_JUMP_LITERAL |=> flushed_o &&
    prog_addr_o == $past(prog_addr_o) + {{6{$past(ir_q.lit[8])}}, $past(ir_q.lit)} ##1 !retired_o)
    else $error("literal jump target or timing wrong");
  AST_JUMP_W: assert property (ex && ir_q.op == CSBE_OP_RELATIVE_JUMP_WREG |=> flushed_o &&
    prog_addr_o == $past(prog_addr_o) + {7'h00, $past(w_o)} ##1 !retired_o)
    else $error("W jump target or timing wrong");
  AST_SKIP: assert property (ex && ir_q.op == CSBE_OP_BIT_TEST_SKIP_CLEAR |=>
    prog_addr_o == $past(prog_addr_o) + 15'h0001 && $stable({w_o, carry_o, zero_o}))
    else $error("bit test moved PC or flags wrongly");
  AST_FLUSH_NOP: assert property (flushed_o |=>
    !retired_o && prog_addr_o == $past(prog_addr_o) + 15'h0001 && $stable(w_o))
    else $error("discarded slot did work");
  AST_ILLEGAL: assert property (illegal_o |-> !retired_o && !flushed_o && $stable({w_o, carry_o, zero_o}))
    else $error("out-of-slice code did work");
  AST_REAL_NOP: assert property (ex && ir_q.op == CSBE_OP_NOP |=>
    retired_o && !illegal_o && $stable({w_o, carry_o, zero_o}))
    else $error("plain no-operation not retired");
endmodule

`default_nettype wire

// [dv/csbe_core_tb.sv]
// Self-checking bench for csbe_core with a combinational program store.
// Assumes the design files and the checker are compiled first.
`default_nettype none

module csbe_core_tb
  import csbe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [FADDR_W-1:0] FA = 7'h7f; // Top of file range
  localparam logic [PC_W-1:0] R = 15'h0011;
  typedef struct packed {csbe_instr_t i; logic [7:0] w; logic c; logic z;} csbe_row_t;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [PC_W-1:0] prog_addr_o;
  csbe_instr_t instr_i;
  logic [DATA_W-1:0] w_o, dbg_data_o;
  logic carry_o, zero_o, retired_o, flushed_o, illegal_o;
  logic [FADDR_W-1:0] dbg_addr_i = FA;
  csbe_instr_t prog [0:32767];
  csbe_row_t rows [0:16];
  int mismatches = 0;
  int checks = 0;

  // Clock and program store
  always #50 core_clk_i = ~core_clk_i;
  assign instr_i = prog[prog_addr_o];

  csbe_core dut (.core_clk_i, .srst_i, .prog_addr_o, .instr_i, .w_o, .carry_o, .zero_o,
    .retired_o, .flushed_o, .illegal_o, .dbg_addr_i, .dbg_data_o);

  function automatic csbe_instr_t mk(csbe_op_t op, logic d, logic [2:0] b, logic [8:0] k);
    return '{op: op, faddr: FA, dest: d, bit_idx: b, lit: k};
  endfunction

  task automatic chk(logic [14:0] got, logic [14:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Effects of an edge are read at the following falling edge
  task automatic step;
    @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Rows: file byte built to 81 first, then logic and shift cases
  initial begin
    for (int a = 0; a < 32768; a++) prog[a] = INSTR_NOP;
    for (int b = 0; b < 8; b++) rows[b] = '{mk((b % 7) ? CSBE_OP_BIT_CLEAR_FILE : CSBE_OP_BIT_SET_FILE,
      0, b[2:0], 0), 8'h00, 1'b0, 1'b0};
    rows[8] = '{mk(CSBE_OP_ARITH_SHIFT_RIGHT_FILE, 0, 0, 0), 8'hc0, 1'b1, 1'b0};
    rows[9] = '{mk(CSBE_OP_AND_LITERAL_W, 0, 0, 9'h04f), 8'h40, 1'b1, 1'b0};
    rows[10] = '{mk(CSBE_OP_AND_W_FILE, 0, 0, 0), 8'h00, 1'b1, 1'b1};
    rows[11] = '{mk(CSBE_OP_ARITH_SHIFT_RIGHT_FILE, 1, 0, 0), 8'h00, 1'b1, 1'b0};
    rows[12] = '{mk(CSBE_OP_ARITH_SHIFT_RIGHT_FILE, 0, 0, 0), 8'he0, 1'b0, 1'b0};
    rows[13] = '{mk(CSBE_OP_AND_LITERAL_W, 0, 0, 9'h0ff), 8'he0, 1'b0, 1'b0};
    rows[14] = '{mk(CSBE_OP_AND_W_FILE, 1, 0, 0), 8'he0, 1'b0, 1'b0};
    rows[15] = '{mk(CSBE_OP_BIT_CLEAR_FILE, 0, 7, 0), 8'he0, 1'b0, 1'b0};
    rows[16] = '{mk(CSBE_OP_ARITH_SHIFT_RIGHT_FILE, 0, 0, 0), 8'h20, 1'b0, 1'b0};
    for (int a = 0; a < 17; a++) prog[a] = rows[a].i;
    // Flow section; and with zero marks slots that must never run
    prog[R] = mk(CSBE_OP_BIT_TEST_SKIP_CLEAR, 0, 7, 0);
    prog[R+1] = mk(CSBE_OP_AND_LITERAL_W, 0, 0, 0);
    prog[R+2] = mk(CSBE_OP_BIT_TEST_SKIP_CLEAR, 0, 6, 0);
    prog[R+3] = mk(CSBE_OP_RELATIVE_JUMP_LITERAL, 0, 0, 9'h002);
    prog[R+4] = mk(CSBE_OP_AND_LITERAL_W, 0, 0, 0);
    prog[R+6] = mk(CSBE_OP_RELATIVE_JUMP_WREG, 0, 0, 0);
    prog[R+39] = mk(CSBE_OP_RELATIVE_JUMP_LITERAL, 0, 0, 9'h100);
    // Code outside the slice at the backward target; it must act as a NOP
    prog[15'(R + 40 - 256)] = mk(csbe_op_t'(4'hf), 0, 0, 0);
    repeat (8) @(negedge core_clk_i);
    chk(prog_addr_o, RESET_PC);
    chk(w_o, RESET_W);
    chk({carry_o, zero_o, retired_o, flushed_o, illegal_o}, 0);
    srst_i = 1'b0;
    step;
    for (int a = 0; a < 17; a++) begin
      step;
      chk(w_o, rows[a].w);
      chk({carry_o, zero_o}, {rows[a].c, rows[a].z});
    end
    $display("row tests done");
    step;
    chk(prog_addr_o, 15'(R + 2));
    chk(flushed_o, 1'b1);
    step;
    chk(retired_o, 1'b0);
    chk(w_o, 8'h20);
    step;
    chk(prog_addr_o, 15'(R + 4));
    chk(flushed_o, 1'b0);
    step;
    chk(prog_addr_o, 15'(R + 6));
    step;
    step;
    chk(prog_addr_o, 15'(R + 39));
    step;
    step;
    chk(prog_addr_o, 15'(R + 40 - 256));
    chk({w_o, carry_o, zero_o}, {8'h20, 2'b00});
    chk(dbg_data_o, 8'h40);
    step;
    chk(retired_o, 1'b0);
    chk(prog_addr_o, 15'(R + 41 - 256));
    $display("flow tests done");
    // Out-of-slice code: flagged, not retired, no state touched
    step;
    chk({illegal_o, retired_o, flushed_o}, 3'b100);
    chk({w_o, carry_o, zero_o}, {8'h20, 2'b00});
    step;
    chk({illegal_o, retired_o}, 2'b01);
    step;
    $display("illegal code test done");
    // Mid-run reset, then a second release
    srst_i = 1'b1;
    step;
    chk(prog_addr_o, RESET_PC);
    chk(w_o, RESET_W);
    chk(dbg_data_o, 8'h00);
    chk({carry_o, zero_o, flushed_o, illegal_o}, 4'h0);
    srst_i = 1'b0;
    step;
    chk(prog_addr_o, 15'h0001);
    chk(w_o, RESET_W);
    step;
    chk(prog_addr_o, 15'h0002);
    chk({w_o, carry_o, zero_o, flushed_o, illegal_o}, 12'h000);
    $display("reset test done");
    give_verdict();
  end
endmodule

bind csbe_core csbe_core_assertions asrt (.core_clk_i, .srst_i, .prog_addr_o, .instr_i, .w_o,
  .carry_o, .zero_o, .retired_o, .flushed_o, .illegal_o);

`default_nettype wire
